// ===== core/bcb_defs.vh
`ifndef BCB_DEFS_VH
`define BCB_DEFS_VH
// ==========================================================
// Register offsets
`define BCB_OFF_BRCTL   8'h3c
`define BCB_OFF_DBUF    8'h40
`define BCB_OFF_ISTAT   8'h44
`define BCB_OFF_IMASK   8'h48
`define BCB_OFF_STAT    8'h4c
// ==========================================================
// Bridge control field positions
`define BCB_B_SERREN    17
`define BCB_B_ISA       18
`define BCB_B_VGA       19
`define BCB_B_VGA16     20
`define BCB_B_MAMODE    21
`define BCB_B_SECRST    22
`define BCB_B_FBB       23
`define BCB_B_PTMO      24
`define BCB_B_STMO      25
`define BCB_B_TMOSTS    26
`define BCB_B_DTSERR    27
// ==========================================================
// Data buffering field positions
`define BCB_B_PARK      0
`define BCB_B_PFDIS     1
`define BCB_B_PREDDIS   2
// ==========================================================
// Interrupt status bits
`define BCB_I_PTMO      0
`define BCB_I_STMO      1
// ==========================================================
// Timer lengths, log2 of PCI clocks
`define BCB_TMO_LONG    15
`define BCB_TMO_SHORT   10
`define BCB_LIM_LONG    15'h7fff
`define BCB_LIM_SHORT   15'h03ff
`define BCB_ZERO32      32'h00000000
`define BCB_ONES32      32'hffffffff
`endif

// ===== core/bcb_ctrl.v
// Summary of operation
// [RULE_01] VGA enable forwards VGA memory and I/O when enables set, ignoring ISA.
// [RULE_02] VGA I/O decode uses 10 address bits at 0, 16 bits at 1.
// [RULE_03] Master-abort mode 0: no report, reads return all ones, writes dropped.
// [RULE_04] Mode 1: signal target abort if possible, else system error if enabled.
// [RULE_05] Secondary reset holds PCI reset forward, hot reset reverse.
// [RULE_06] Fast back-to-back enable reads as zero.
// [RULE_07] Primary discard timer 2^15 clocks at 0, 2^10 at 1.
// [RULE_08] Forward mode: primary timeout select read-only and ignored.
// [RULE_09] Secondary discard timer 2^15 clocks at 0, 2^10 at 1.
// [RULE_10] Reverse mode: secondary timeout select read-only and ignored.
// [RULE_11] Discard timer expiry with dropped completion sets timeout status.
// [RULE_12] Discard error enable makes expiry send error message or system error.
// [RULE_13] Arbiter parks on last master at 0, own port at 1.
// [RULE_14] Prefetch dynamic control applied unless disable bit set.
// [RULE_15] Completion data prediction used unless control bit set.
// [RULE_16] Reset clears writable and status fields of both registers.
// [RULE_17] System-error forwarding enable gates messages; writable forward only.
// [RULE_18] Write one clears timeout status; new event wins over clear.
`timescale 1ns/1ps
`include "bcb_defs.vh"
module bcb_ctrl #(
   parameter ADDR_W = 8
)(
   input  wire              clk,
   input  wire              rst_n,
   input  wire              reverse_mode,
   input  wire [ADDR_W-1:0] reg_addr,
   input  wire [31:0]       reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [31:0]       reg_rdata,
   input  wire              io_enable,
   input  wire              mem_enable,
   input  wire              acc_valid,
   input  wire              acc_is_io,
   input  wire [31:0]       acc_addr,
   input  wire              win_hit,
   input  wire              p_dc_pending,
   input  wire              p_dc_taken,
   input  wire              s_dc_pending,
   input  wire              s_dc_taken,
   input  wire              mabort,
   input  wire              mabort_is_read,
   input  wire              tabort_possible,
   input  wire              sys_error_in,
   input  wire              cur_master_valid,
   input  wire [3:0]        cur_master,
   output reg               fwd_hit,
   output reg  [31:0]       mabort_rdata,
   output reg               mabort_drop_wr,
   output reg               target_abort,
   output reg               system_error_out_n,
   output reg               primary_system_error_n,
   output reg               err_msg,
   output reg               sec_pci_reset_n,
   output reg               pcie_hot_reset,
   output reg               p_discard,
   output reg               s_discard,
   output reg  [3:0]        park_master,
   output reg               park_self,
   output reg               prefetch_dyn_en,
   output reg               pred_en,
   output reg               irq
);
   // ==========================================================
   // Control registers
   reg        serren_ff, vga_ff, vga16_ff, mamode_ff, secrst_ff, isa_ff;
   reg        ptmo_ff, stmo_ff, tmosts_ff, dtserr_ff;
   reg        park_ff, pfdis_ff, preddis_ff;
   reg [1:0]  istat_ff, imask_ff;
   reg [14:0] pcnt_ff, scnt_ff;
   reg [3:0]  last_m_ff;
   wire       wr_br = reg_wr && (reg_addr == `BCB_OFF_BRCTL);
   wire       wr_db = reg_wr && (reg_addr == `BCB_OFF_DBUF);
   wire       wr_is = reg_wr && (reg_addr == `BCB_OFF_ISTAT);
   wire       wr_im = reg_wr && (reg_addr == `BCB_OFF_IMASK);
   // ==========================================================
   // Discard timers
   // [RULE_07] primary length select
   wire [14:0] p_lim = (!reverse_mode || !ptmo_ff) ? `BCB_LIM_LONG : `BCB_LIM_SHORT;
   // [RULE_09] secondary length select
   wire [14:0] s_lim = (reverse_mode || !stmo_ff) ? `BCB_LIM_LONG : `BCB_LIM_SHORT;
   wire        p_exp = p_dc_pending && !p_dc_taken && (pcnt_ff == p_lim);
   wire        s_exp = s_dc_pending && !s_dc_taken && (scnt_ff == s_lim);
   wire        any_exp = p_exp || s_exp;
   // ==========================================================
   // VGA decode
   // [RULE_02] 10 or 16 bit I/O decode
   wire        io_hi_ok = vga16_ff ? (acc_addr[15:10] == 6'h00) : 1'b1;
   wire [9:0]  io_lo = acc_addr[9:0];
   wire        vga_io = io_hi_ok && ((io_lo >= 10'h3b0 && io_lo <= 10'h3bb) ||
                        (io_lo >= 10'h3c0 && io_lo <= 10'h3df));
   wire        vga_mem = (acc_addr >= 32'h000a0000) && (acc_addr <= 32'h000bffff);
   // [RULE_01] VGA forwarding independent of ISA
   wire        vga_hit = vga_ff && (acc_is_io ? (io_enable && vga_io)
                                              : (mem_enable && vga_mem));
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // [RULE_16] reset clears fields
         serren_ff <= 1'b0; vga_ff <= 1'b0; vga16_ff <= 1'b0; mamode_ff <= 1'b0;
         secrst_ff <= 1'b0; isa_ff <= 1'b0; ptmo_ff <= 1'b0; stmo_ff <= 1'b0;
         tmosts_ff <= 1'b0; dtserr_ff <= 1'b0; park_ff <= 1'b0; pfdis_ff <= 1'b0;
         preddis_ff <= 1'b0; istat_ff <= 2'h0; imask_ff <= 2'h0;
         pcnt_ff <= 15'h0000; scnt_ff <= 15'h0000; last_m_ff <= 4'h0;
         reg_rdata <= `BCB_ZERO32; fwd_hit <= 1'b0; mabort_rdata <= `BCB_ZERO32;
         mabort_drop_wr <= 1'b0; target_abort <= 1'b0; system_error_out_n <= 1'b1;
         primary_system_error_n <= 1'b1; err_msg <= 1'b0; sec_pci_reset_n <= 1'b1;
         pcie_hot_reset <= 1'b0; p_discard <= 1'b0; s_discard <= 1'b0;
         park_master <= 4'h0; park_self <= 1'b0; prefetch_dyn_en <= 1'b0;
         pred_en <= 1'b0; irq <= 1'b0;
      end
      else
      begin
         if (wr_br)
         begin
            // [RULE_17] writable in forward only
            if (!reverse_mode)
               serren_ff <= reg_wdata[`BCB_B_SERREN];
            isa_ff    <= reg_wdata[`BCB_B_ISA];
            vga_ff    <= reg_wdata[`BCB_B_VGA];
            vga16_ff  <= reg_wdata[`BCB_B_VGA16];
            mamode_ff <= reg_wdata[`BCB_B_MAMODE];
            secrst_ff <= reg_wdata[`BCB_B_SECRST];
            dtserr_ff <= reg_wdata[`BCB_B_DTSERR];
            // [RULE_08] primary select read-only forward
            if (reverse_mode)
               ptmo_ff <= reg_wdata[`BCB_B_PTMO];
            // [RULE_10] secondary select read-only reverse
            if (!reverse_mode)
               stmo_ff <= reg_wdata[`BCB_B_STMO];
         end
         // [RULE_11] set on discard
         // [RULE_18] set wins over clear
         if (any_exp)
            tmosts_ff <= 1'b1;
         else if (wr_br && reg_wdata[`BCB_B_TMOSTS])
            tmosts_ff <= 1'b0;
         if (wr_db)
         begin
            park_ff    <= reg_wdata[`BCB_B_PARK];
            pfdis_ff   <= reg_wdata[`BCB_B_PFDIS];
            preddis_ff <= reg_wdata[`BCB_B_PREDDIS];
         end
         if (wr_im)
            imask_ff <= reg_wdata[1:0];
         istat_ff <= (istat_ff & ~(wr_is ? reg_wdata[1:0] : 2'h0)) | {s_exp, p_exp};
         irq <= |(istat_ff & imask_ff);
         pcnt_ff <= (p_dc_pending && !p_dc_taken && !p_exp) ? pcnt_ff + 15'h0001 : 15'h0000;
         scnt_ff <= (s_dc_pending && !s_dc_taken && !s_exp) ? scnt_ff + 15'h0001 : 15'h0000;
         p_discard <= p_exp;
         s_discard <= s_exp;
         // ==========================================================
         // Read data
         if (reg_rd)
         begin
            if (reg_addr == `BCB_OFF_BRCTL)
               // [RULE_06] fast back-to-back zero
               reg_rdata <= {4'h0, dtserr_ff, tmosts_ff, stmo_ff, ptmo_ff, 1'b0,
                             secrst_ff, mamode_ff, vga16_ff, vga_ff, isa_ff,
                             serren_ff, 17'h00000};
            else if (reg_addr == `BCB_OFF_DBUF)
               reg_rdata <= {29'h00000000, preddis_ff, pfdis_ff, park_ff};
            else if (reg_addr == `BCB_OFF_ISTAT)
               reg_rdata <= {30'h00000000, istat_ff};
            else if (reg_addr == `BCB_OFF_IMASK)
               reg_rdata <= {30'h00000000, imask_ff};
            else if (reg_addr == `BCB_OFF_STAT)
               reg_rdata <= {29'h00000000, irq, reverse_mode, tmosts_ff};
            else
               reg_rdata <= `BCB_ZERO32;
         end
         else
            reg_rdata <= `BCB_ZERO32;
         // ==========================================================
         // Forwarding and master abort
         fwd_hit <= acc_valid && (vga_hit || win_hit);
         // [RULE_03] silent abort handling
         mabort_rdata   <= (mabort && mabort_is_read) ? `BCB_ONES32 : `BCB_ZERO32;
         mabort_drop_wr <= mabort && !mabort_is_read && !mamode_ff;
         // [RULE_04] report by target abort or system error
         target_abort <= mabort && mamode_ff && tabort_possible;
         system_error_out_n <= !((mabort && mamode_ff && !tabort_possible && serren_ff)
                                 || (sys_error_in && serren_ff));
         // [RULE_12] discard timer error signalling
         err_msg <= (any_exp && dtserr_ff && !reverse_mode) ||
                    (sys_error_in && serren_ff && !reverse_mode);
         primary_system_error_n <= !(any_exp && dtserr_ff && reverse_mode);
         // [RULE_05] secondary reset
         sec_pci_reset_n <= !(secrst_ff && !reverse_mode);
         pcie_hot_reset  <= secrst_ff && reverse_mode;
         // [RULE_13] arbiter parking
         if (cur_master_valid)
            last_m_ff <= cur_master;
         park_self   <= park_ff;
         park_master <= last_m_ff;
         // [RULE_14] prefetch dynamic control
         prefetch_dyn_en <= !pfdis_ff;
         // [RULE_15] completion prediction
         pred_en <= !preddis_ff;
      end
   end
endmodule // bcb_ctrl

// ===== tb/bcb_far.sv
`timescale 1ns/1ps
// ==========
// Completion holder that never collects its data
module bcb_far (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic discard,
   output logic      pending,
   output logic      taken
);
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) pending <= 1'b0;
      else if (discard) pending <= 1'b0;
      else if (start) pending <= 1'b1;
   end
   assign taken = 1'b0;
endmodule // bcb_far

// ===== tb/bcb_ctrl_chk.sv
`timescale 1ns/1ps
module bcb_ctrl_chk #(parameter ADDR_W = 8) (
   input wire logic clk, rst_n, reverse_mode, reg_rd, reg_wr,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_rdata, mabort_rdata,
   input wire logic acc_valid, acc_is_io, io_enable, mem_enable, win_hit,
   input wire logic mabort, mabort_is_read, tabort_possible, p_dc_pending,
   input wire logic p_dc_taken, s_dc_pending, s_dc_taken, fwd_hit, mabort_drop_wr,
   input wire logic target_abort, pcie_hot_reset, p_discard, s_discard, irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Waiting-cycle counters
   logic [15:0] pc_ff, sc_ff;
   logic        evt;
   assign evt = p_discard | s_discard | reg_wr;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) begin pc_ff <= 16'h0; sc_ff <= 16'h0; end
      else
      begin
         pc_ff <= (p_dc_pending && !p_dc_taken) ? pc_ff + 16'h1 : 16'h0;
         sc_ff <= (s_dc_pending && !s_dc_taken) ? sc_ff + 16'h1 : 16'h0;
      end
   end
   sequence brctl_rd;
      $past(reg_rd) && $past(reg_addr) == 8'h3c;
   endsequence
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   fbb_zero_a: assert property (brctl_rd |-> !reg_rdata[23])
      else $error("fast back-to-back bit set");
   hot_rst_a: assert property (!reverse_mode |-> !pcie_hot_reset)
      else $error("hot reset in forward mode");
   p_len_a: assert property (p_discard |-> pc_ff >= 16'd1023)
      else $error("primary discard too early");
   s_len_a: assert property (s_discard |-> sc_ff >= 16'd1023)
      else $error("secondary discard too early");
   irq_cause_a: assert property ($rose(irq) |-> $past(evt) || $past(evt, 2))
      else $error("interrupt without cause");
   fwd_cause_a: assert property (fwd_hit |-> $past(acc_valid) && ($past(win_hit)
      || ($past(acc_is_io) ? $past(io_enable) : $past(mem_enable))))
      else $error("forward without enable");
   tabort_cause_a: assert property (target_abort |-> $past(mabort && tabort_possible))
      else $error("target abort without cause");
   wr_drop_a: assert property (mabort_drop_wr |-> $past(mabort && !mabort_is_read))
      else $error("write drop without abort");
   mab_data_a: assert property ($past(mabort && mabort_is_read) |-> mabort_rdata == 32'hffffffff)
      else $error("abort data not all ones");
endmodule // bcb_ctrl_chk
bind bcb_ctrl bcb_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst_n, .reverse_mode, .reg_rd,
   .reg_wr, .reg_addr, .reg_rdata, .mabort_rdata, .acc_valid, .acc_is_io, .io_enable,
   .mem_enable, .win_hit, .mabort, .mabort_is_read, .tabort_possible, .p_dc_pending,
   .p_dc_taken, .s_dc_pending, .s_dc_taken, .fwd_hit, .mabort_drop_wr, .target_abort,
   .pcie_hot_reset, .p_discard, .s_discard, .irq);

// ===== tb/bridge_control_and_buffering_bench.sv
`timescale 1ns/1ps
`include "bcb_defs.vh"
module bridge_control_and_buffering_bench;
   logic clk = 0, rst_n = 0, rev = 0, rd = 0, wr = 0, ioe = 0, av = 0, aio = 0, st = 0;
   logic ma = 0, mard = 0, tap = 0, fwd, drop, ta, srst_n, hrst, pd, sd, ps, pf, pr, irq;
   logic pp, pt, me = 0, wh = 0;
   logic [7:0] ad = 8'h0;
   logic [31:0] wd = 32'h0, aa = 32'h0, rdata, mrd;
   int mismatches = 0, tests_run = 0, n;
   initial forever #5 clk = ~clk;
   bcb_ctrl u_dut (.clk, .rst_n, .reverse_mode(rev), .reg_addr(ad), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .io_enable(ioe), .mem_enable(me),
      .acc_valid(av), .acc_is_io(aio), .acc_addr(aa), .win_hit(wh), .p_dc_pending(pp),
      .p_dc_taken(pt), .s_dc_pending(1'b0), .s_dc_taken(1'b0), .mabort(ma),
      .mabort_is_read(mard), .tabort_possible(tap), .sys_error_in(1'b0),
      .cur_master_valid(1'b0), .cur_master(4'h0), .fwd_hit(fwd), .mabort_rdata(mrd),
      .mabort_drop_wr(drop), .target_abort(ta), .system_error_out_n(),
      .primary_system_error_n(), .err_msg(), .sec_pci_reset_n(srst_n),
      .pcie_hot_reset(hrst), .p_discard(pd), .s_discard(sd), .park_master(),
      .park_self(ps), .prefetch_dyn_en(pf), .pred_en(pr), .irq);
   bcb_far u_far (.clk, .rst_n, .start(st), .discard(pd), .pending(pp), .taken(pt));
   task chk(string nm, logic [31:0] s, logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task wreg(logic [7:0] a, logic [31:0] d);
      @(posedge clk); ad <= a; wd <= d; wr <= 1;
      @(posedge clk); wr <= 0;
   endtask
   task rchk(string nm, logic [7:0] a, logic [31:0] e);
      @(posedge clk); ad <= a; rd <= 1;
      @(posedge clk); rd <= 0;
      @(negedge clk); chk(nm, rdata, e);
   endtask
   task acc(logic io, logic [31:0] a, logic e);
      @(posedge clk); aio <= io; aa <= a; av <= 1;
      @(posedge clk); av <= 0;
      @(negedge clk); chk("fwd_hit", fwd, e);
   endtask
   // ==========
   // Scenarios
   task t_regs;
      rchk("brctl", `BCB_OFF_BRCTL, 0);
      rchk("dbuf", `BCB_OFF_DBUF, 0);
      rchk("unmapped", 8'h50, 0);
      wreg(`BCB_OFF_BRCTL, 32'hffffffff);
      rchk("brctl_ro", `BCB_OFF_BRCTL, 32'h0a7e0000);
      chk("sec_reset", {srst_n, hrst}, 2'b00);
      wreg(`BCB_OFF_BRCTL, 0);
      repeat (2) @(negedge clk);
      chk("sec_reset_off", {srst_n, hrst}, 2'b10);
   endtask
   task t_vga;
      ioe <= 1;
      wreg(`BCB_OFF_BRCTL, 32'h00080000);
      acc(1, 32'h3c0, 1);
      acc(1, 32'h43c0, 1);
      acc(0, 32'ha0000, 0);
      @(posedge clk); me <= 1;
      acc(0, 32'ha0000, 1);
      wreg(`BCB_OFF_BRCTL, 32'h00180000);
      acc(1, 32'h43c0, 0);
      wreg(`BCB_OFF_BRCTL, 0);
      acc(1, 32'h3c0, 0);
      @(posedge clk); wh <= 1;
      acc(1, 32'h3c0, 1);
      @(posedge clk); wh <= 0; me <= 0;
   endtask
   task t_mab;
      for (int m = 0; m < 2; m++)
      begin
         wreg(`BCB_OFF_BRCTL, m ? 32'h00200000 : 32'h0);
         @(posedge clk); ma <= 1; mard <= 1; tap <= 1;
         @(posedge clk); ma <= 0;
         @(negedge clk);
         if (m == 0) chk("abort_data", mrd, 32'hffffffff);
         chk("target_abort", ta, m);
      end
   endtask
   task t_dbuf;
      wreg(`BCB_OFF_DBUF, 32'h7);
      rchk("dbuf", `BCB_OFF_DBUF, 32'h7);
      chk("dbuf_on", {ps, pf, pr}, 3'b100);
      wreg(`BCB_OFF_DBUF, 32'h0);
      repeat (2) @(negedge clk);
      chk("dbuf_off", {ps, pf, pr}, 3'b011);
   endtask
   task t_timer;
      rev <= 1;
      wreg(`BCB_OFF_IMASK, 32'h1);
      wreg(`BCB_OFF_BRCTL, 32'h09000000);
      @(posedge clk); st <= 1;
      @(posedge clk); st <= 0;
      n = 0;
      while (!pd && n < 2000) begin @(negedge clk); n++; end
      if (n >= 2000) begin mismatches++; summarize; end
      chk("tmo_len", (n >= 1020 && n <= 1030), 1);
      repeat (2) @(negedge clk);
      chk("irq_set", irq, 1);
      rchk("stat", `BCB_OFF_STAT, 32'h7);
      rchk("tmo_sts", `BCB_OFF_BRCTL, 32'h0d000000);
      wreg(`BCB_OFF_BRCTL, 32'h09000000);
      rchk("w0_keep", `BCB_OFF_BRCTL, 32'h0d000000);
      wreg(`BCB_OFF_BRCTL, 32'h0d000000);
      rchk("w1_clr", `BCB_OFF_BRCTL, 32'h09000000);
      wreg(`BCB_OFF_ISTAT, 32'h1);
      repeat (2) @(negedge clk);
      chk("irq_clr", irq, 0);
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1;
      t_regs; t_vga; t_mab; t_dbuf; t_timer;
      summarize;
   end
endmodule // bridge_control_and_buffering_bench
